// file: sim/bit_exec_sva.sv
`timescale 1ns/1ps
// port-level checks on branch, flag, bit and load timing
module bit_exec_sva
    import exec_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic opValid,
    input wire logic opReady,
    input wire exec_pkg::op_e opCode,
    input wire logic [exec_pkg::OFFSET_W-1:0] opOffset,
    input wire logic [3:0] opReg,
    input wire logic [2:0] opBit,
    input wire logic memRead,
    input wire logic [exec_pkg::PC_W-1:0] memAddr,
    input wire logic [exec_pkg::PC_W-1:0] pcOut,
    input wire logic [7:0] statusFlags
);
    import exec_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    logic go; // request taken this edge
    logic isBr; // any conditional branch
    logic take; // branch condition holds
    logic [PC_W-1:0] kExt; // sign-extended displacement
    // decode of the request under test
    always_comb begin
        go = opValid && opReady;
        kExt = {{(PC_W-OFFSET_W){opOffset[OFFSET_W-1]}}, opOffset};
        isBr = opCode inside {OP_BRANCH_TRANSFER_CLEAR, OP_BRANCH_OVF_SET,
            OP_BRANCH_OVF_CLEAR, OP_BRANCH_INT_ON, OP_BRANCH_INT_OFF};
        case (opCode)
            OP_BRANCH_TRANSFER_CLEAR: take = !statusFlags[FLAG_T];
            OP_BRANCH_OVF_SET: take = statusFlags[FLAG_V];
            OP_BRANCH_OVF_CLEAR: take = !statusFlags[FLAG_V];
            OP_BRANCH_INT_ON: take = statusFlags[FLAG_I];
            OP_BRANCH_INT_OFF: take = !statusFlags[FLAG_I];
            default: take = 1'b0;
        endcase
    end
    ////////////////////////////////////////////////////////////////
    sequence s_taken; go && isBr && take; endsequence
    sequence s_stall_done; !opReady ##1 opReady; endsequence
    sequence s_postinc;
        go && opCode == OP_LOAD_INDIRECT_INC && opReg != X_LOW_IDX && opReg != X_HIGH_IDX;
    endsequence
    ////////////////////////////////////////////////////////////////
    a_branch_take: assert property (s_taken |=> s_stall_done ##0
        pcOut == $past(pcOut, 2) + $past(kExt, 2) + 16'h0001)
        else $error("taken branch pc or timing wrong");
    a_branch_skip: assert property (go && isBr && !take |=>
        opReady && pcOut == $past(pcOut) + 16'h0001)
        else $error("untaken branch pc or timing wrong");
    a_branch_keep: assert property (go && isBr |=> $stable(statusFlags))
        else $error("branch changed flags");
    a_flag_set: assert property (go && opCode == OP_FLAG_SET |=>
        statusFlags == ($past(statusFlags) | (8'h01 << $past(opBit))))
        else $error("flag set wrong");
    a_flag_clear: assert property (go && opCode == OP_FLAG_CLEAR |=>
        statusFlags == ($past(statusFlags) & ~(8'h01 << $past(opBit))))
        else $error("flag clear wrong");
    a_bit_keep: assert property (go && opCode inside {OP_IO_BIT_SET, OP_IO_BIT_CLEAR,
        OP_COPY_TRANSFER_TO_BIT} |=> $stable(statusFlags) && opReady)
        else $error("bit op touched flags or stalled");
    a_only_transfer: assert property (go && opCode == OP_COPY_BIT_TO_TRANSFER |=>
        (statusFlags & 8'hBF) == ($past(statusFlags) & 8'hBF))
        else $error("bit store touched other flags");
    a_shift_single: assert property (go && opCode inside {OP_SHIFT_LEFT_LOGICAL,
        OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY,
        OP_SHIFT_RIGHT_ARITH} |=> opReady && pcOut == $past(pcOut) + 16'h0001)
        else $error("shift not single cycle");
    a_postinc_x: assert property (s_postinc |-> memRead ##1 s_stall_done ##0
        memAddr == $past(memAddr, 2) + 16'h0001)
        else $error("post-increment load wrong");
    a_load_keep: assert property (go && opCode inside {OP_LOAD_INDIRECT,
        OP_LOAD_INDIRECT_INC} |-> memRead ##1 $stable(statusFlags))
        else $error("load changed flags or gave no read");
endmodule // bit_exec_sva

bind bit_exec_unit bit_exec_sva chk_u (.clock, .rst, .opValid, .opReady, .opCode,
    .opOffset, .opReg, .opBit, .memRead, .memAddr, .pcOut, .statusFlags);

// file: sim/test_cpu_branch_bit_shift_ops.sv
`timescale 1ns/1ps
// self-checking bench for the bit, shift and branch unit
module test_cpu_branch_bit_shift_ops;
    import exec_pkg::*;
    logic clock = 1'b0; // 25 mhz core clock
    logic rst = 1'b1; // async reset
    logic ce = 1'b1; // clock enable
    logic opValid = 1'b0;
    logic opReady, memRead, memReady = 1'b1;
    op_e opCode = OP_NOP;
    logic [OFFSET_W-1:0] opOffset = '0;
    logic [3:0] opReg = '0, peekReg = '0;
    logic [2:0] opBit = '0;
    logic [4:0] opIoAddr = '0, peekIo = '0;
    logic [7:0] opImm = '0, memRdata = '0, statusFlags, peekRegData, peekIoData;
    logic [PC_W-1:0] memAddr, pcOut;
    logic [15:0] pc; // expected program counter
    logic [7:0] fl; // expected flags
    int err_count = 0, compares = 0, cyc = 0;
    always #20 clock = ~clock;
    bit_exec_unit dut_u (.clock(clock), .rst(rst), .ce(ce), .opValid(opValid),
        .opReady(opReady), .opCode(opCode), .opOffset(opOffset), .opReg(opReg),
        .opBit(opBit), .opIoAddr(opIoAddr), .opImm(opImm), .memRead(memRead),
        .memAddr(memAddr), .memReady(memReady), .memRdata(memRdata), .pcOut(pcOut),
        .statusFlags(statusFlags), .peekReg(peekReg), .peekRegData(peekRegData),
        .peekIo(peekIo), .peekIoData(peekIoData));
    ////////////////////////////////////////////////////////////////
    // one comparison, counted
    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // present a request, hold it until the edge that takes it
    task automatic issue(input op_e op, input logic [6:0] k, input logic [3:0] r,
        input logic [2:0] b, input logic [7:0] imm);
        int n;
        n = 0;
        @(posedge clock);
        opCode <= op; opOffset <= k; opReg <= r; opBit <= b; opImm <= imm;
        opIoAddr <= {r[3], r}; peekReg <= r; peekIo <= {r[3], r};
        opValid <= 1'b1;
        @(negedge clock);
        while (opReady !== 1'b1 && n < 20) begin
            n++;
            @(negedge clock);
        end
        @(posedge clock);
        opValid <= 1'b0;
    endtask
    // single-edge operation, pc steps by one
    task automatic run(input op_e op, input logic [3:0] r, input logic [2:0] b,
        input logic [7:0] imm);
        issue(op, 7'h00, r, b, imm);
        @(negedge clock);
        pc = pc + 16'h0001;
        check("pc", pc, pcOut);
        check("ready", 16'h0001, 16'(opReady));
    endtask
    // two-edge operation, ready drops for one cycle
    task automatic run2(input op_e op, input logic [3:0] r);
        issue(op, 7'h00, r, 3'h0, 8'h00);
        @(negedge clock);
        check("stall", 16'h0000, 16'(opReady));
        @(negedge clock);
        pc = pc + 16'h0001;
        check("pc", pc, pcOut);
    endtask
    // force one flag via the set or clear op
    task automatic setf(input int i, input logic v);
        if (v) run(OP_FLAG_SET, 4'h0, i[2:0], 8'h00);
        else run(OP_FLAG_CLEAR, 4'h0, i[2:0], 8'h00);
        fl[i] = v;
    endtask
    ////////////////////////////////////////////////////////////////
    // every flag set then cleared, one at a time
    task automatic t_flag_ops();
        // ce low first: the first request must wait for it
        @(posedge clock);
        ce <= 1'b0;
        @(negedge clock);
        check("held ready", 16'h0000, 16'(opReady));
        ce <= #100 1'b1;
        for (int i = 0; i < 8; i++) begin
            setf(i, 1'b1);
            check("flags set", 16'(fl), 16'(statusFlags));
        end
        for (int i = 0; i < 8; i++) begin
            setf(i, 1'b0);
            check("flags clear", 16'(fl), 16'(statusFlags));
        end
    endtask
    // each branch with its flag both ways, odd-indexed branches forward, even-indexed backward
    task automatic t_branch();
        op_e bo[5] = '{OP_BRANCH_TRANSFER_CLEAR, OP_BRANCH_OVF_SET, OP_BRANCH_OVF_CLEAR,
            OP_BRANCH_INT_ON, OP_BRANCH_INT_OFF};
        int fb[5] = '{FLAG_T, FLAG_V, FLAG_V, FLAG_I, FLAG_I};
        logic pol[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        logic [6:0] k;
        for (int i = 0; i < 5; i++) begin
            for (int v = 0; v < 2; v++) begin
                k = i[0] ? 7'h05 : 7'h7D;
                setf(fb[i], v[0]);
                issue(bo[i], k, 4'h0, 3'h0, 8'h00);
                @(negedge clock);
                if (v[0] == pol[i]) begin
                    check("taken stall", 16'h0000, 16'(opReady));
                    @(negedge clock);
                    pc = pc + {{9{k[6]}}, k} + 16'h0001;
                end else begin
                    pc = pc + 16'h0001;
                end
                check("branch pc", pc, pcOut);
                check("branch flags", 16'(fl), 16'(statusFlags));
            end
        end
    endtask
    // each shift on two operands with carry in both states
    task automatic t_shift();
        op_e so[5] = '{OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_LEFT_CARRY,
            OP_ROTATE_RIGHT_CARRY, OP_SHIFT_RIGHT_ARITH};
        logic [7:0] a, r;
        logic c, cin;
        for (int i = 0; i < 5; i++) begin
            for (int j = 0; j < 2; j++) begin
                a = j[0] ? 8'h01 : 8'h98;
                cin = ~j[0];
                run(OP_LOAD_IMMEDIATE, 4'h3, 3'h0, a);
                setf(FLAG_C, cin);
                run(so[i], 4'h3, 3'h0, 8'h00);
                case (i)
                    0: r = {a[6:0], 1'b0};
                    1: r = {1'b0, a[7:1]};
                    2: r = {a[6:0], cin};
                    3: r = {cin, a[7:1]};
                    default: r = {a[7], a[7:1]};
                endcase
                c = (i == 0 || i == 2) ? a[7] : a[0];
                fl[FLAG_C] = c;
                fl[FLAG_Z] = (r == 8'h00);
                fl[FLAG_N] = r[7];
                fl[FLAG_V] = r[7] ^ c;
                if (i == 0 || i == 2) fl[FLAG_H] = a[3];
                check("shift result", 16'(r), 16'(peekRegData));
                check("shift flags", 16'(fl), 16'(statusFlags));
            end
        end
    endtask
    // i/o bits at both ends of the map, bit copies through transfer
    task automatic t_bits();
        run(OP_IO_BIT_SET, 4'h0, 3'h5, 8'h00);
        check("io 0", 16'h0020, 16'(peekIoData));
        run(OP_IO_BIT_SET, 4'hF, 3'h7, 8'h00);
        check("io 31 set", 16'h0080, 16'(peekIoData));
        run(OP_IO_BIT_CLEAR, 4'hF, 3'h7, 8'h00);
        check("io 31 clear", 16'h0000, 16'(peekIoData));
        check("io flags", 16'(fl), 16'(statusFlags));
        run(OP_LOAD_IMMEDIATE, 4'h4, 3'h0, 8'h10);
        run(OP_COPY_BIT_TO_TRANSFER, 4'h4, 3'h4, 8'h00);
        fl[FLAG_T] = 1'b1;
        check("store one", 16'(fl), 16'(statusFlags));
        run(OP_COPY_BIT_TO_TRANSFER, 4'h4, 3'h3, 8'h00);
        fl[FLAG_T] = 1'b0;
        check("store zero", 16'(fl), 16'(statusFlags));
        setf(FLAG_T, 1'b1);
        run(OP_COPY_TRANSFER_TO_BIT, 4'h4, 3'h0, 8'h00);
        check("bit load", 16'h0011, 16'(peekRegData));
        check("bit load flags", 16'(fl), 16'(statusFlags));
    endtask
    // loads through x, fast and slow memory, increment across a byte carry
    task automatic t_load();
        run(OP_LOAD_IMMEDIATE, X_LOW_IDX, 3'h0, 8'hFF);
        run(OP_LOAD_IMMEDIATE, X_HIGH_IDX, 3'h0, 8'h12);
        check("x", 16'h12FF, memAddr);
        @(posedge clock);
        memRdata <= 8'h5A;
        run(OP_LOAD_INDIRECT, 4'h5, 3'h0, 8'h00);
        check("load fast", 16'h005A, 16'(peekRegData));
        @(posedge clock);
        memReady <= 1'b0;
        memRdata <= 8'hC3;
        run2(OP_LOAD_INDIRECT, 4'h6);
        check("load slow", 16'h00C3, 16'(peekRegData));
        @(posedge clock);
        memRdata <= 8'h3C;
        run2(OP_LOAD_INDIRECT_INC, 4'h7);
        check("load inc", 16'h003C, 16'(peekRegData));
        check("x inc", 16'h1300, memAddr);
        check("load flags", 16'(fl), 16'(statusFlags));
    endtask
    ////////////////////////////////////////////////////////////////
    // counts, verdict and end of run
    task automatic give_verdict();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // hang guard
    always @(posedge clock) begin
        cyc++;
        if (cyc > 5000) begin
            err_count++;
            give_verdict();
        end
    end
    // main sequence
    initial begin
        pc = 16'h0000;
        fl = 8'h00;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        t_flag_ops();
        t_branch();
        t_shift();
        t_bits();
        t_load();
        give_verdict();
    end
endmodule // test_cpu_branch_bit_shift_ops

// file: src/bit_exec_unit.sv
`timescale 1ns/1ps
// How it works
// RL1: branch when transfer clear, pc gets pc+k+1
// RL2: overflow branch pair adds k+1, flags untouched
// RL3: interrupt-state branch pair adds k+1
// RL4: shift left logical, updates z c n v h
// RL5: shift right logical, updates z c n v
// RL6: rotate left through carry, z c n v h
// RL7: rotate right through carry, z c n v
// RL8: arithmetic shift right keeps sign bit
// RL9: one-cycle set of any single flag
// RL10: one-cycle clear of any single flag
// RL11: set or clear one i/o bit
// RL12: copy register bit into transfer flag
// RL13: copy transfer flag into register bit
// RL14: load through x, post-increment takes two
// RL15: branch not taken one cycle, taken two
module bit_exec_unit
    import exec_pkg::*;
#(
    parameter int REGS = exec_pkg::REG_COUNT,
    parameter int IOS = exec_pkg::IO_COUNT
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic opValid,
    output logic opReady,
    input wire exec_pkg::op_e opCode,
    input wire logic [exec_pkg::OFFSET_W-1:0] opOffset,
    input wire logic [3:0] opReg,
    input wire logic [2:0] opBit,
    input wire logic [4:0] opIoAddr,
    input wire logic [7:0] opImm,
    output logic memRead,
    output logic [exec_pkg::PC_W-1:0] memAddr,
    input wire logic memReady,
    input wire logic [7:0] memRdata,
    output logic [exec_pkg::PC_W-1:0] pcOut,
    output logic [7:0] statusFlags,
    input wire logic [3:0] peekReg,
    output logic [7:0] peekRegData,
    input wire logic [4:0] peekIo,
    output logic [7:0] peekIoData
);
    import exec_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // state record
    typedef struct packed {
        state_e state;                  // sequencer state
        logic [PC_W-1:0] pc;            // program counter
        logic [7:0] flags;              // status_flags
        logic [REGS-1:0][7:0] regs;     // working registers
        logic [IOS-1:0][7:0] io;        // i/o registers
        logic [OFFSET_W-1:0] offset;    // held branch displacement
        logic [3:0] dest;               // held load destination
        logic postInc;                  // held post-increment request
    } unit_s;

    unit_s state_reg;
    unit_s state_next;

    ////////////////////////////////////////////////////////////////////
    // decode helpers
    // branch condition for the five conditional branches
    function automatic logic branchTaken(input op_e op, input logic [7:0] f);
        case (op)
            OP_BRANCH_TRANSFER_CLEAR: branchTaken = !f[FLAG_T]; // [RL1]
            OP_BRANCH_OVF_SET: branchTaken = f[FLAG_V];         // [RL2]
            OP_BRANCH_OVF_CLEAR: branchTaken = !f[FLAG_V];      // [RL2]
            OP_BRANCH_INT_ON: branchTaken = f[FLAG_I];          // [RL3]
            OP_BRANCH_INT_OFF: branchTaken = !f[FLAG_I];        // [RL3]
            default: branchTaken = 1'b0;
        endcase
    endfunction

    // map a shift opcode onto the shifter function
    function automatic shift_e shiftFunc(input op_e op);
        case (op)
            OP_SHIFT_LEFT_LOGICAL: shiftFunc = SH_LEFT;
            OP_SHIFT_RIGHT_LOGICAL: shiftFunc = SH_RIGHT;
            OP_ROTATE_LEFT_CARRY: shiftFunc = SH_RLC;
            OP_ROTATE_RIGHT_CARRY: shiftFunc = SH_RRC;
            default: shiftFunc = SH_ARITH;
        endcase
    endfunction

    // pc plus sign-extended displacement plus one
    function automatic logic [PC_W-1:0] branchTarget(input logic [PC_W-1:0] pc,
                                                     input logic [OFFSET_W-1:0] k);
        logic [PC_W-1:0] ext;
        ext = {{(PC_W-OFFSET_W){k[OFFSET_W-1]}}, k};
        branchTarget = pc + ext + 16'h0001;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // shifter
    logic [7:0] shiftResult; // shifted register value
    logic [7:0] shiftFlags;  // flags after the shift

    shift_unit u_shift (
        .operand(state_reg.regs[opReg]),
        .carryIn(state_reg.flags[FLAG_C]),
        .func(shiftFunc(opCode)),
        .result(shiftResult),
        .flagsOut(shiftFlags),
        .flagsIn(state_reg.flags)
    );

    ////////////////////////////////////////////////////////////////////
    // pointer and handshake
    logic [PC_W-1:0] xPtr; // x pointer from r27:r26
    logic accept;          // operation taken this cycle

    assign xPtr = {state_reg.regs[X_HIGH_IDX], state_reg.regs[X_LOW_IDX]};
    assign opReady = ce && (state_reg.state == ST_IDLE);
    assign accept = opReady && opValid;
    assign memAddr = xPtr;
    // read strobe is raised only in the first load cycle, memAddr always shows x
    assign memRead = accept && ((opCode == OP_LOAD_INDIRECT)
                                || (opCode == OP_LOAD_INDIRECT_INC));
    assign pcOut = state_reg.pc;
    assign statusFlags = state_reg.flags;
    assign peekRegData = state_reg.regs[peekReg];
    assign peekIoData = state_reg.io[peekIo];

    ////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        logic [PC_W-1:0] pcPlusOne;
        logic [PC_W-1:0] xNext;
        pcPlusOne = state_reg.pc + 16'h0001;
        xNext = xPtr + 16'h0001;
        state_next = state_reg;
        if (ce) begin
            case (state_reg.state)
                ST_IDLE: begin
                    if (opValid) begin
                        case (opCode)
                            OP_BRANCH_TRANSFER_CLEAR, OP_BRANCH_OVF_SET,
                            OP_BRANCH_OVF_CLEAR, OP_BRANCH_INT_ON,
                            OP_BRANCH_INT_OFF: begin
                                // taken: second cycle writes target
                                if (branchTaken(opCode, state_reg.flags)) begin // [RL15]
                                    state_next.offset = opOffset;
                                    state_next.state = ST_BRANCH;
                                end else begin
                                    state_next.pc = pcPlusOne; // [RL15]
                                end
                            end
                            OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL,
                            OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY,
                            OP_SHIFT_RIGHT_ARITH: begin
                                // single-cycle shift with flags
                                state_next.regs[opReg] = shiftResult; // [RL4] [RL5] [RL8]
                                state_next.flags = shiftFlags;       // [RL6] [RL7]
                                state_next.pc = pcPlusOne;
                            end
                            OP_FLAG_SET: begin
                                state_next.flags[opBit] = 1'b1; // [RL9]
                                state_next.pc = pcPlusOne;
                            end
                            OP_FLAG_CLEAR: begin
                                state_next.flags[opBit] = 1'b0; // [RL10]
                                state_next.pc = pcPlusOne;
                            end
                            OP_IO_BIT_SET: begin
                                state_next.io[opIoAddr][opBit] = 1'b1; // [RL11]
                                state_next.pc = pcPlusOne;
                            end
                            OP_IO_BIT_CLEAR: begin
                                state_next.io[opIoAddr][opBit] = 1'b0; // [RL11]
                                state_next.pc = pcPlusOne;
                            end
                            OP_COPY_BIT_TO_TRANSFER: begin
                                state_next.flags[FLAG_T] = state_reg.regs[opReg][opBit]; // [RL12]
                                state_next.pc = pcPlusOne;
                            end
                            OP_COPY_TRANSFER_TO_BIT: begin
                                state_next.regs[opReg][opBit] = state_reg.flags[FLAG_T]; // [RL13]
                                state_next.pc = pcPlusOne;
                            end
                            OP_LOAD_INDIRECT: begin
                                // ready memory finishes in one cycle
                                if (memReady) begin
                                    state_next.regs[opReg] = memRdata; // [RL14]
                                    state_next.pc = pcPlusOne;
                                end else begin
                                    state_next.dest = opReg;
                                    state_next.postInc = 1'b0;
                                    state_next.state = ST_LOAD;
                                end
                            end
                            OP_LOAD_INDIRECT_INC: begin
                                // always two cycles, data taken in the second
                                state_next.dest = opReg;
                                state_next.postInc = 1'b1; // [RL14]
                                state_next.state = ST_LOAD;
                            end
                            OP_LOAD_IMMEDIATE: begin
                                state_next.regs[opReg] = opImm;
                                state_next.pc = pcPlusOne;
                            end
                            default: begin
                                state_next.pc = pcPlusOne;
                            end
                        endcase
                    end
                end
                ST_BRANCH: begin
                    // second cycle of a taken branch
                    state_next.pc = branchTarget(state_reg.pc, state_reg.offset); // [RL1] [RL2] [RL3]
                    state_next.state = ST_IDLE;
                end
                ST_LOAD: begin
                    // late data, then optional pointer bump
                    state_next.regs[state_reg.dest] = memRdata; // [RL14]
                    if (state_reg.postInc) begin
                        state_next.regs[X_LOW_IDX] = xNext[7:0]; // [RL14]
                        state_next.regs[X_HIGH_IDX] = xNext[15:8];
                        if (state_reg.dest == X_LOW_IDX) begin
                            state_next.regs[X_LOW_IDX] = xNext[7:0];
                        end
                    end
                    state_next.pc = pcPlusOne;
                    state_next.postInc = 1'b0;
                    state_next.state = ST_IDLE;
                end
                default: begin
                    state_next.state = ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg.state <= ST_IDLE;
            state_reg.pc <= PC_RESET;
            state_reg.flags <= FLAGS_RESET;
            state_reg.regs <= '0;
            state_reg.io <= '0;
            state_reg.offset <= '0;
            state_reg.dest <= 4'h0;
            state_reg.postInc <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule // bit_exec_unit

// file: src/exec_pkg.sv
// shared constants and types for the bit/shift/branch execution unit
package exec_pkg;

    // core widths
    localparam int PC_W = 16;           // program counter width
    localparam int REG_COUNT = 16;      // working registers r16..r31
    localparam int IO_COUNT = 32;       // bit-addressable i/o registers
    localparam int OFFSET_W = 7;        // signed branch displacement k

    // status flag positions
    localparam int FLAG_C = 0;          // carry
    localparam int FLAG_Z = 1;          // zero
    localparam int FLAG_N = 2;          // negative
    localparam int FLAG_V = 3;          // two's complement overflow
    localparam int FLAG_S = 4;          // signed test
    localparam int FLAG_H = 5;          // half carry
    localparam int FLAG_T = 6;          // transfer bit
    localparam int FLAG_I = 7;          // global interrupt enable

    // pointer location inside the register file (x = high:low)
    localparam logic [3:0] X_LOW_IDX = 4'hA;   // r26
    localparam logic [3:0] X_HIGH_IDX = 4'hB;  // r27

    // reset values
    localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // timing counts in core cycles
    localparam int BRANCH_TAKEN_CYCLES = 2;
    localparam int BRANCH_NOT_TAKEN_CYCLES = 1;
    localparam int LOAD_POSTINC_CYCLES = 2;

    // operation codes presented to the unit
    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_BRANCH_TRANSFER_CLEAR = 5'h01,
        OP_BRANCH_OVF_SET = 5'h02,
        OP_BRANCH_OVF_CLEAR = 5'h03,
        OP_BRANCH_INT_ON = 5'h04,
        OP_BRANCH_INT_OFF = 5'h05,
        OP_SHIFT_LEFT_LOGICAL = 5'h06,
        OP_SHIFT_RIGHT_LOGICAL = 5'h07,
        OP_ROTATE_LEFT_CARRY = 5'h08,
        OP_ROTATE_RIGHT_CARRY = 5'h09,
        OP_SHIFT_RIGHT_ARITH = 5'h0A,
        OP_FLAG_SET = 5'h0B,
        OP_FLAG_CLEAR = 5'h0C,
        OP_IO_BIT_SET = 5'h0D,
        OP_IO_BIT_CLEAR = 5'h0E,
        OP_COPY_BIT_TO_TRANSFER = 5'h0F,
        OP_COPY_TRANSFER_TO_BIT = 5'h10,
        OP_LOAD_INDIRECT = 5'h11,
        OP_LOAD_INDIRECT_INC = 5'h12,
        OP_LOAD_IMMEDIATE = 5'h13
    } op_e;

    // shifter function select
    typedef enum logic [2:0] {
        SH_LEFT = 3'h0,
        SH_RIGHT = 3'h1,
        SH_RLC = 3'h2,
        SH_RRC = 3'h3,
        SH_ARITH = 3'h4
    } shift_e;

    // sequencer states, one bit flips on every transition
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_BRANCH = 2'h1,
        ST_LOAD = 2'h2
    } state_e;

endpackage

// file: src/shift_unit.sv
`timescale 1ns/1ps
// single-cycle shifter and rotator with flag results
module shift_unit
    import exec_pkg::*;
(
    input wire logic [7:0] operand,
    input wire logic carryIn,
    input wire shift_e func,
    output logic [7:0] result,
    output logic [7:0] flagsOut,
    input wire logic [7:0] flagsIn
);
    import exec_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // result and flag computation
    always_comb begin
        logic carryOut;
        logic neg;
        carryOut = 1'b0;
        neg = 1'b0;
        result = operand;
        flagsOut = flagsIn;
        case (func)
            SH_LEFT: begin
                result = {operand[6:0], 1'b0}; // [RL4]
                carryOut = operand[7];
                flagsOut[FLAG_H] = operand[3]; // [RL4]
            end
            SH_RIGHT: begin
                result = {1'b0, operand[7:1]}; // [RL5]
                carryOut = operand[0];
            end
            SH_RLC: begin
                result = {operand[6:0], carryIn}; // [RL6]
                carryOut = operand[7];
                flagsOut[FLAG_H] = operand[3]; // [RL6]
            end
            SH_RRC: begin
                result = {carryIn, operand[7:1]}; // [RL7]
                carryOut = operand[0];
            end
            SH_ARITH: begin
                result = {operand[7], operand[7:1]}; // [RL8]
                carryOut = operand[0];
            end
            default: begin
                result = operand;
                carryOut = carryIn;
            end
        endcase
        // shared z, c, n, v update for every shift
        neg = result[7];
        flagsOut[FLAG_C] = carryOut; // [RL4] [RL5] [RL6] [RL7] [RL8]
        flagsOut[FLAG_Z] = (result == 8'h00);
        flagsOut[FLAG_N] = neg;
        flagsOut[FLAG_V] = neg ^ carryOut;
    end

endmodule // shift_unit
